/* qurm_regs.vh */
// Register map constants for the quad UART channel register block
`ifndef QURM_REGS_VH
`define QURM_REGS_VH
`define QURM_ADDR_DATA 3'h0
`define QURM_ADDR_IER 3'h1
`define QURM_ADDR_ISR 3'h2
`define QURM_ADDR_LCR 3'h3
`define QURM_ADDR_MCR 3'h4
`define QURM_ADDR_LSR 3'h5
`define QURM_ADDR_MSR 3'h6
`define QURM_ADDR_SPR 3'h7
`define QURM_LCR_ENH 8'hBF
`define QURM_LCR_DIVEN 7
`define QURM_EFR_ENH_BIT 4
`define QURM_RST_BYTE 8'h00
`define QURM_IER_GATED 8'hF0
`define QURM_FCR_GATED 8'h30
`define QURM_MCR_GATED 8'hE0
`define QURM_ISR_GATED 8'h30
`define QURM_DLD_MASK 8'h3F
`define QURM_MCR_MASK 8'hFB
`define QURM_FCR_RXRST 1
`define QURM_FCR_TXRST 2
`define QURM_FCR_EN 0
`define QURM_ISR_NOINT 8'h01
`endif

/* qurm_channel.v */
// One UART channel register set with bank decoding
`timescale 1ns/1ns
`default_nettype none
`include "qurm_regs.vh"
module qurm_channel (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_sel,
   input wire i_wr,
   input wire i_rd,
   input wire [2:0] i_addr,
   input wire [7:0] i_wdata,
   input wire [7:0] i_rx_data,
   input wire [5:0] i_int_source,
   input wire [7:0] i_line_status,
   input wire [7:0] i_modem_status,
   output wire [7:0] o_rdata,
   output reg [7:0] o_tx_data,
   output reg o_tx_load,
   output reg o_rx_pop,
   output reg o_msr_read,
   output reg o_rx_fifo_reset,
   output reg o_tx_fifo_reset,
   output wire [7:0] o_ier,
   output wire [7:0] o_fcr,
   output wire [7:0] o_lcr,
   output wire [7:0] o_mcr,
   output wire [15:0] o_divisor,
   output wire [7:0] o_fraction,
   output wire [7:0] o_efr,
   output wire [31:0] o_flow_chars
);
   reg [7:0] ier_reg, fcr_reg, lcr_reg, mcr_reg, spr_reg, dll_reg, dlm_reg, dld_reg, efr_reg;
   reg [7:0] xon1_reg, xon2_reg, xoff1_reg, xoff2_reg;
   reg [7:0] rdata;
   wire enh_bank = (lcr_reg == `QURM_LCR_ENH);
   wire div_bank = lcr_reg[`QURM_LCR_DIVEN] && !enh_bank;
   wire norm_bank = !lcr_reg[`QURM_LCR_DIVEN];
   wire enh_on = efr_reg[`QURM_EFR_ENH_BIT];
   wire wr = i_sel && i_wr;
   // Gated bits: writes dropped and reads zero while enhanced mode is off
   function [7:0] gate;
      input [7:0] val;
      input [7:0] mask;
      input en;
      begin
         gate = en ? val : (val & ~mask);
      end
   endfunction
   // Writes keep the old gated bits while enhanced mode is off
   function [7:0] merge;
      input [7:0] val;
      input [7:0] old;
      input [7:0] mask;
      input en;
      begin
         merge = en ? val : ((val & ~mask) | (old & mask));
      end
   endfunction
   assign o_ier = ier_reg;
   assign o_fcr = fcr_reg;
   assign o_lcr = lcr_reg;
   assign o_mcr = mcr_reg;
   assign o_divisor = {dlm_reg, dll_reg};
   assign o_fraction = enh_on ? dld_reg : `QURM_RST_BYTE;
   assign o_efr = efr_reg;
   assign o_flow_chars = {xoff2_reg, xoff1_reg, xon2_reg, xon1_reg};
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ier_reg <= `QURM_RST_BYTE;
         fcr_reg <= `QURM_RST_BYTE;
         lcr_reg <= `QURM_RST_BYTE;
         mcr_reg <= `QURM_RST_BYTE;
         spr_reg <= `QURM_RST_BYTE;
         dll_reg <= `QURM_RST_BYTE;
         dlm_reg <= `QURM_RST_BYTE;
         dld_reg <= `QURM_RST_BYTE;
         efr_reg <= `QURM_RST_BYTE;
         xon1_reg <= `QURM_RST_BYTE;
         xon2_reg <= `QURM_RST_BYTE;
         xoff1_reg <= `QURM_RST_BYTE;
         xoff2_reg <= `QURM_RST_BYTE;
         o_tx_data <= `QURM_RST_BYTE;
         o_tx_load <= 1'b0;
         o_rx_fifo_reset <= 1'b0;
         o_tx_fifo_reset <= 1'b0;
      end else begin
         o_tx_load <= 1'b0;
         o_rx_fifo_reset <= 1'b0;
         o_tx_fifo_reset <= 1'b0;
         if (wr) begin
            case (i_addr)
               `QURM_ADDR_DATA: begin
                  if (norm_bank) begin
                     o_tx_data <= i_wdata;
                     o_tx_load <= 1'b1;
                  end else if (div_bank) begin
                     dll_reg <= i_wdata;
                  end
               end
               `QURM_ADDR_IER: begin
                  if (norm_bank)
                     ier_reg <= merge(i_wdata, ier_reg, `QURM_IER_GATED, enh_on);
                  else if (div_bank)
                     dlm_reg <= i_wdata;
               end
               `QURM_ADDR_ISR: begin
                  if (enh_bank) begin
                     efr_reg <= i_wdata;
                  end else if (div_bank) begin
                     if (enh_on)
                        dld_reg <= i_wdata & `QURM_DLD_MASK;
                  end else begin
                     fcr_reg <= merge(i_wdata, fcr_reg, `QURM_FCR_GATED, enh_on);
                     o_rx_fifo_reset <= i_wdata[`QURM_FCR_RXRST];
                     o_tx_fifo_reset <= i_wdata[`QURM_FCR_TXRST];
                  end
               end
               `QURM_ADDR_LCR: lcr_reg <= i_wdata;
               `QURM_ADDR_MCR: begin
                  if (enh_bank)
                     xon1_reg <= i_wdata;
                  else
                     mcr_reg <= merge(i_wdata & `QURM_MCR_MASK, mcr_reg, `QURM_MCR_GATED,
                        enh_on);
               end
               `QURM_ADDR_LSR: if (enh_bank) xon2_reg <= i_wdata;
               `QURM_ADDR_MSR: if (enh_bank) xoff1_reg <= i_wdata;
               `QURM_ADDR_SPR: begin
                  if (enh_bank)
                     xoff2_reg <= i_wdata;
                  else
                     spr_reg <= i_wdata;
               end
               default: ;
            endcase
         end
      end
   end
   // Read side effects: receive pop and modem status read
   always @* begin
      o_rx_pop = i_sel && i_rd && norm_bank && (i_addr == `QURM_ADDR_DATA);
      o_msr_read = i_sel && i_rd && !enh_bank && (i_addr == `QURM_ADDR_MSR);
   end
   always @* begin
      rdata = `QURM_RST_BYTE;
      case (i_addr)
         `QURM_ADDR_DATA: begin
            if (norm_bank)
               rdata = i_rx_data;
            else if (div_bank)
               rdata = dll_reg;
         end
         `QURM_ADDR_IER: begin
            if (norm_bank)
               rdata = gate(ier_reg, `QURM_IER_GATED, enh_on);
            else if (div_bank)
               rdata = dlm_reg;
         end
         `QURM_ADDR_ISR: begin
            if (enh_bank)
               rdata = efr_reg;
            else if (div_bank)
               rdata = enh_on ? dld_reg : `QURM_RST_BYTE;
            else
               rdata = gate({fcr_reg[`QURM_FCR_EN], fcr_reg[`QURM_FCR_EN], i_int_source},
                  `QURM_ISR_GATED, enh_on);
         end
         `QURM_ADDR_LCR: rdata = lcr_reg;
         `QURM_ADDR_MCR:
            rdata = enh_bank ? xon1_reg : gate(mcr_reg, `QURM_MCR_GATED, enh_on);
         `QURM_ADDR_LSR: rdata = enh_bank ? xon2_reg : i_line_status;
         `QURM_ADDR_MSR: rdata = enh_bank ? xoff1_reg : i_modem_status;
         `QURM_ADDR_SPR: rdata = enh_bank ? xoff2_reg : spr_reg;
         default: rdata = `QURM_RST_BYTE;
      endcase
   end
   assign o_rdata = rdata;
endmodule
`default_nettype wire

/* qurm_top.v */
// Four-channel UART register map with FIFO status read
`timescale 1ns/1ns
`default_nettype none
`include "qurm_regs.vh"
// Summary of operation
// - Each of four channels has its own register set, 3-bit address.
// - Normal bank address 0 reads receive byte, writes transmit byte.
// - Divisor bank (bit7 set, not BF) maps divisor low, high, fraction.
// - Value BF maps enhanced function and four flow characters.
// - Status select low reads ready byte, RX high nibble, TX low, active low.
// - Upper enables and some status/control bits need enhanced bit 4.
// - Interrupt enable register at 1 is read/write, eight enables.
// - Address 2 read gives FIFO-enabled bits and interrupt source.
// - Address 2 write loads FIFO control fields.
// - Line control at 3 holds framing, break and divisor enable.
// - Modem control at 4 drives terminal-ready, send-request and modes.
// - Line status at 5 is read-only receive and transmit state.
// - Modem status at 6 gives change flags and input levels.
// - Address 7 normal bank is a plain scratch byte.
// - Fraction register holds fraction and sampling mode bits.
// - Four flow-control characters are full 8-bit read/write.
// - Enhanced function register reachable only with value BF.
// - Enhanced bit 4 gates access to the listed bits.
module qurm_top #(
   parameter NCH = 4
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire [NCH-1:0] i_chan_sel_n,
   input wire i_wr_n,
   input wire i_rd_n,
   input wire [2:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_fifo_status_select_n,
   input wire [8*NCH-1:0] i_rx_data,
   input wire [6*NCH-1:0] i_int_source,
   input wire [8*NCH-1:0] i_line_status,
   input wire [8*NCH-1:0] i_modem_status,
   input wire [NCH-1:0] i_rx_ready_n,
   input wire [NCH-1:0] i_tx_ready_n,
   output reg [7:0] o_rdata,
   output wire [8*NCH-1:0] o_tx_data,
   output wire [NCH-1:0] o_tx_load,
   output wire [NCH-1:0] o_rx_pop,
   output wire [NCH-1:0] o_msr_read,
   output wire [NCH-1:0] o_rx_fifo_reset,
   output wire [NCH-1:0] o_tx_fifo_reset,
   output wire [8*NCH-1:0] o_ier,
   output wire [8*NCH-1:0] o_fcr,
   output wire [8*NCH-1:0] o_lcr,
   output wire [8*NCH-1:0] o_mcr,
   output wire [16*NCH-1:0] o_divisor,
   output wire [8*NCH-1:0] o_fraction,
   output wire [8*NCH-1:0] o_efr,
   output wire [32*NCH-1:0] o_flow_chars
);
   // Host strobes and ready flags come from pins: two-stage sync
   reg [NCH-1:0] csn_s1, csn_s2;
   reg wrn_s1, wrn_s2, wrn_d, rdn_s1, rdn_s2, rdn_d, fsn_s1, fsn_s2;
   reg [NCH-1:0] rxr_s1, rxr_s2, txr_s1, txr_s2;
   // Address and data are pins too; they settle before the strobe does
   reg [2:0] addr_s1, addr_s2;
   reg [7:0] wdat_s1, wdat_s2;
   wire [8*NCH-1:0] ch_rdata;
   wire wr_pulse = !wrn_s2 && wrn_d;
   wire rd_pulse = !rdn_s2 && rdn_d;
   integer k;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         csn_s1 <= {NCH{1'b1}};
         csn_s2 <= {NCH{1'b1}};
         wrn_s1 <= 1'b1;
         wrn_s2 <= 1'b1;
         wrn_d <= 1'b1;
         rdn_s1 <= 1'b1;
         rdn_s2 <= 1'b1;
         rdn_d <= 1'b1;
         fsn_s1 <= 1'b1;
         fsn_s2 <= 1'b1;
         rxr_s1 <= {NCH{1'b1}};
         rxr_s2 <= {NCH{1'b1}};
         txr_s1 <= {NCH{1'b1}};
         txr_s2 <= {NCH{1'b1}};
         addr_s1 <= 3'h0;
         addr_s2 <= 3'h0;
         wdat_s1 <= `QURM_RST_BYTE;
         wdat_s2 <= `QURM_RST_BYTE;
      end else begin
         csn_s1 <= i_chan_sel_n;
         csn_s2 <= csn_s1;
         wrn_s1 <= i_wr_n;
         wrn_s2 <= wrn_s1;
         wrn_d <= wrn_s2;
         rdn_s1 <= i_rd_n;
         rdn_s2 <= rdn_s1;
         rdn_d <= rdn_s2;
         fsn_s1 <= i_fifo_status_select_n;
         fsn_s2 <= fsn_s1;
         rxr_s1 <= i_rx_ready_n;
         rxr_s2 <= rxr_s1;
         txr_s1 <= i_tx_ready_n;
         txr_s2 <= txr_s1;
         addr_s1 <= i_addr;
         addr_s2 <= addr_s1;
         wdat_s1 <= i_wdata;
         wdat_s2 <= wdat_s1;
      end
   end
   // Status read bypasses channels so no pop side effect fires
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch
         qurm_channel u_ch (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_sel(!csn_s2[g] && fsn_s2),
            .i_wr(wr_pulse),
            .i_rd(rd_pulse),
            .i_addr(addr_s2),
            .i_wdata(wdat_s2),
            .i_rx_data(i_rx_data[8*g +: 8]),
            .i_int_source(i_int_source[6*g +: 6]),
            .i_line_status(i_line_status[8*g +: 8]),
            .i_modem_status(i_modem_status[8*g +: 8]),
            .o_rdata(ch_rdata[8*g +: 8]),
            .o_tx_data(o_tx_data[8*g +: 8]),
            .o_tx_load(o_tx_load[g]),
            .o_rx_pop(o_rx_pop[g]),
            .o_msr_read(o_msr_read[g]),
            .o_rx_fifo_reset(o_rx_fifo_reset[g]),
            .o_tx_fifo_reset(o_tx_fifo_reset[g]),
            .o_ier(o_ier[8*g +: 8]),
            .o_fcr(o_fcr[8*g +: 8]),
            .o_lcr(o_lcr[8*g +: 8]),
            .o_mcr(o_mcr[8*g +: 8]),
            .o_divisor(o_divisor[16*g +: 16]),
            .o_fraction(o_fraction[8*g +: 8]),
            .o_efr(o_efr[8*g +: 8]),
            .o_flow_chars(o_flow_chars[32*g +: 32])
         );
      end
   endgenerate
   reg [7:0] rdata_next;
   always @* begin
      rdata_next = `QURM_RST_BYTE;
      if (!fsn_s2) begin
         rdata_next = {rxr_s2[3:0], txr_s2[3:0]};
      end else begin
         for (k = 0; k < NCH; k = k + 1)
            if (!csn_s2[k])
               rdata_next = ch_rdata[8*k +: 8];
      end
   end
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n)
         o_rdata <= `QURM_RST_BYTE;
      else
         o_rdata <= rdata_next;
   end
endmodule
`default_nettype wire

/* qurm_host.sv */
// Host bus model issuing register cycles
`timescale 1ns/1ns
`default_nettype none
module qurm_host (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output var logic [3:0] o_cs_n,
   output var logic o_wr_n,
   output var logic o_rd_n,
   output var logic [2:0] o_addr,
   output var logic [7:0] o_wdata
);
   initial begin
      o_cs_n = 4'hF;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      o_addr = 3'h0;
      o_wdata = 8'h00;
   end
   // Select goes out a cycle early, it passes the same sync depth
   task automatic acc(input int ch, input bit rd, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      @(negedge i_clk);
      o_cs_n = ~(4'h1 << ch);
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      if (rd) begin
         o_rd_n = 1'b0;
      end else begin
         o_wr_n = 1'b0;
      end
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      q = i_rdata;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_wdata = ~d;
      repeat (3) @(negedge i_clk);
      o_cs_n = 4'hF;
   endtask
endmodule
`default_nettype wire

/* qurm_checker.sv */
// Port assertions for the quad UART register map
`timescale 1ns/1ns
`default_nettype none
module qurm_checker #(
   parameter NCH = 4
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_rd_n,
   input wire logic i_fifo_status_select_n,
   input wire logic [NCH-1:0] i_rx_ready_n,
   input wire logic [NCH-1:0] i_tx_ready_n,
   input wire logic [7:0] o_rdata,
   input wire logic [NCH-1:0] o_tx_load,
   input wire logic [8*NCH-1:0] o_ier,
   input wire logic [8*NCH-1:0] o_fcr,
   input wire logic [8*NCH-1:0] o_lcr,
   input wire logic [8*NCH-1:0] o_mcr,
   input wire logic [16*NCH-1:0] o_divisor,
   input wire logic [8*NCH-1:0] o_fraction,
   input wire logic [8*NCH-1:0] o_efr,
   input wire logic [32*NCH-1:0] o_flow_chars
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_div; (!o_lcr[7] || o_lcr[7:0] == 8'hBF) |=> $stable(o_divisor[15:0]); endproperty
   a_div: assert property (p_div) else $error("divisor moved outside its bank");
   property p_flow; o_lcr[7:0] != 8'hBF |=> $stable(o_flow_chars[31:0]); endproperty
   a_flow: assert property (p_flow) else $error("flow chars moved");
   property p_efr; o_lcr[7:0] != 8'hBF |=> $stable(o_efr[7:0]); endproperty
   a_efr: assert property (p_efr) else $error("enhanced reg moved");
   property p_frac; !o_efr[4] |-> o_fraction[7:0] == 8'h00; endproperty
   a_frac: assert property (p_frac) else $error("fraction not zero");
   property p_rsvd; o_fraction[7:6] == 2'h0 && o_mcr[2] == 1'b0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_gate; !o_efr[4] |=> $stable({o_ier[7:4], o_fcr[5:4], o_mcr[7:5]}); endproperty
   a_gate: assert property (p_gate) else $error("gated bit moved");
   property p_load; o_tx_load[0] |-> !o_lcr[7] ##1 !o_tx_load[0]; endproperty
   a_load: assert property (p_load) else $error("bad transmit load");
   // Ready byte needs the sync pipe and output register filled, three cycles; six steady cycles give margin
   property p_fsr; (!i_fifo_status_select_n && !i_rd_n
      && $stable({i_rx_ready_n, i_tx_ready_n})) [*6] |=> o_rdata == {i_rx_ready_n, i_tx_ready_n};
   endproperty
   a_fsr: assert property (p_fsr) else $error("bad ready byte");
endmodule
bind qurm_top qurm_checker #(.NCH(NCH)) chk (.i_clk, .i_rst_n, .i_rd_n, .i_fifo_status_select_n,
   .i_rx_ready_n, .i_tx_ready_n, .o_rdata, .o_tx_load, .o_ier, .o_fcr, .o_lcr, .o_mcr,
   .o_divisor, .o_fraction, .o_efr, .o_flow_chars);
`default_nettype wire

/* qurm_top_tb.sv */
// Self-checking bench for the quad UART register map
`timescale 1ns/1ns
`default_nettype none
module qurm_top_tb;
   logic i_clk, i_rst_n, i_wr_n, i_rd_n, i_fifo_status_select_n;
   logic [3:0] i_chan_sel_n, i_rx_ready_n, i_tx_ready_n, o_tx_load;
   logic [3:0] o_rx_pop, o_msr_read, o_rx_fifo_reset, o_tx_fifo_reset;
   logic [2:0] i_addr;
   logic [7:0] i_wdata, o_rdata, q;
   logic [23:0] i_int_source;
   logic [31:0] i_rx_data, i_line_status, i_modem_status, o_tx_data, o_ier, o_fcr;
   logic [31:0] o_lcr, o_mcr, o_fraction, o_efr;
   logic [63:0] o_divisor;
   logic [127:0] o_flow_chars;
   int err_count, comparisons, cycles;
   int loads, pops, msr_reads, rx_resets, tx_resets;
   qurm_top DUT (.i_clk, .i_rst_n, .i_chan_sel_n, .i_wr_n, .i_rd_n, .i_addr, .i_wdata,
      .i_fifo_status_select_n, .i_rx_data, .i_int_source, .i_line_status, .i_modem_status,
      .i_rx_ready_n, .i_tx_ready_n, .o_rdata, .o_tx_data, .o_tx_load, .o_rx_pop,
      .o_msr_read, .o_rx_fifo_reset, .o_tx_fifo_reset, .o_ier, .o_fcr, .o_lcr,
      .o_mcr, .o_divisor, .o_fraction, .o_efr, .o_flow_chars);
   qurm_host host (.i_clk, .i_rdata(o_rdata), .o_cs_n(i_chan_sel_n), .o_wr_n(i_wr_n),
      .o_rd_n(i_rd_n), .o_addr(i_addr), .o_wdata(i_wdata));
   task automatic report_and_stop;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] d);
      host.acc(ch, 1'b0, a, d, q);
   endtask
   task automatic rd(input int ch, input logic [2:0] a, input logic [7:0] e);
      host.acc(ch, 1'b1, a, 8'h00, q);
      chk(32'(q), 32'(e));
   endtask
   task automatic t_scratch;
      for (int c = 0; c < 4; c++) wr(c, 3'h7, 8'hA0 + 8'(c));
      wr(1, 3'h3, 8'h1B);
      for (int c = 0; c < 4; c++) rd(c, 3'h7, 8'hA0 + 8'(c));
      rd(1, 3'h3, 8'h1B);
   endtask
   task automatic t_normal;
      wr(0, 3'h0, 8'hC3);
      chk(32'(o_tx_data[7:0]), 32'hC3);
      rd(0, 3'h0, 8'h5A);
      chk(32'(loads), 32'h1);
      chk(32'(pops), 32'h1);
      wr(0, 3'h5, 8'hFF);
      rd(0, 3'h5, 8'h61);
      rd(0, 3'h6, 8'hF3);
      chk(32'(msr_reads), 32'h1);
      wr(0, 3'h1, 8'hFF);
      rd(0, 3'h1, 8'h0F);
      wr(0, 3'h4, 8'hFF);
      rd(0, 3'h4, 8'h1B);
      wr(0, 3'h2, 8'hF9);
      chk(32'(o_fcr[7:0]), 32'hC9);
      rd(0, 3'h2, 8'hCC);
   endtask
   task automatic t_banks;
      wr(0, 3'h3, 8'h80);
      wr(0, 3'h0, 8'h12);
      wr(0, 3'h1, 8'h34);
      wr(0, 3'h2, 8'h3F);
      chk(32'(o_divisor[15:0]), 32'h3412);
      rd(0, 3'h1, 8'h34);
      rd(0, 3'h2, 8'h00);
      wr(0, 3'h3, 8'hBF);
      wr(0, 3'h2, 8'h10);
      rd(0, 3'h2, 8'h10);
      for (int i = 0; i < 4; i++) wr(0, 3'(4 + i), 8'h11 * 8'(i + 1));
      chk(o_flow_chars[31:0], 32'h44332211);
      wr(0, 3'h3, 8'h80);
      wr(0, 3'h2, 8'h3F);
      chk(32'(o_fraction[7:0]), 32'h3F);
      wr(0, 3'h3, 8'h00);
      wr(0, 3'h1, 8'hFF);
      rd(0, 3'h1, 8'hFF);
      wr(0, 3'h4, 8'hFF);
      rd(0, 3'h4, 8'hFB);
      wr(0, 3'h2, 8'hF9);
      chk(32'(o_fcr[7:0]), 32'hF9);
      rd(0, 3'h2, 8'hFC);
   endtask
   task automatic t_gated;
      wr(0, 3'h3, 8'hBF);
      wr(0, 3'h2, 8'h00);
      wr(0, 3'h3, 8'h80);
      chk(32'(o_fraction[7:0]), 32'h00);
      wr(0, 3'h3, 8'h00);
      wr(0, 3'h1, 8'h00);
      chk(32'(o_ier[7:0]), 32'hF0);
      rd(0, 3'h1, 8'h00);
      wr(0, 3'h4, 8'h00);
      chk(32'(o_mcr[7:0]), 32'hE0);
      wr(0, 3'h2, 8'h06);
      chk(32'(o_fcr[7:0]), 32'h36);
      chk(32'(rx_resets), 32'h1);
      chk(32'(tx_resets), 32'h1);
   endtask
   task automatic t_fifo_ready_status;
      i_fifo_status_select_n = 1'b0;
      rd(2, 3'h3, 8'hA5);
      i_fifo_status_select_n = 1'b1;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // Pulses last one cycle, so count them mid-cycle
   always @(negedge i_clk) begin
      if (|o_tx_load)
         loads++;
      if (|o_rx_pop)
         pops++;
      if (|o_msr_read)
         msr_reads++;
      if (|o_rx_fifo_reset)
         rx_resets++;
      if (|o_tx_fifo_reset)
         tx_resets++;
   end
   // Roughly 52 accesses of 11 cycles, so the ceiling is generous
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         report_and_stop;
      end
   end
   initial begin
      i_rst_n = 1'b0;
      i_fifo_status_select_n = 1'b1;
      i_rx_data = 32'h0000005A;
      i_line_status = 32'h00000061;
      i_modem_status = 32'h000000F3;
      i_int_source = 24'h00003C;
      i_rx_ready_n = 4'hA;
      i_tx_ready_n = 4'h5;
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      repeat (3) @(negedge i_clk);
      t_scratch;
      t_normal;
      t_banks;
      t_gated;
      t_fifo_ready_status;
      report_and_stop;
   end
endmodule
`default_nettype wire
